// [hw/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;
   // Register byte offsets on the control bus
   localparam int ADDR_W = 8;
   typedef logic [ADDR_W-1:0] addr_t;
   localparam addr_t CFG_OFS = 8'h00;
   localparam addr_t SC2_OFS = 8'h04;
   localparam addr_t AVG_OFS = 8'h08;
   localparam addr_t SC1_OFS = 8'h0C;
   localparam addr_t RH_OFS = 8'h10;
   localparam addr_t RL_OFS = 8'h14;
   localparam addr_t CVH_OFS = 8'h18;
   localparam addr_t CVL_OFS = 8'h1C;
   localparam addr_t PC1_OFS = 8'h20;
   localparam addr_t PC2_OFS = 8'h24;

   // Configuration register fields, bit 7 first
   typedef struct packed {
      logic low_power_config;
      logic [1:0] clock_divide_select;
      logic long_sample_select;
      logic [1:0] resolution_select;
      logic [1:0] input_clock_select;
   } cfg_t;

   // Trigger and compare control fields
   typedef struct packed {
      logic trigger_select;
      logic compare_function_enable;
      logic compare_greater_select;
      logic [1:0] reference_pair_select;
   } sc2_t;

   // Channel status and control fields (flag held apart)
   typedef struct packed {
      logic complete_interrupt_enable;
      logic continuous_select;
      logic differential_select;
      logic [4:0] input_channel_select;
   } sc1_t;

   // Averaging control fields
   typedef struct packed {
      logic averaging_enable;
      logic [1:0] average_count_select;
   } avg_t;

   // Reset values
   localparam cfg_t CFG_RST = 8'h00;
   localparam sc2_t SC2_RST = 5'h00;
   localparam sc1_t SC1_RST = 8'h1F;
   localparam avg_t AVG_RST = 3'h0;

   // Resolution encodings
   localparam logic [1:0] RES_8 = 2'h0;
   localparam logic [1:0] RES_12 = 2'h1;
   localparam logic [1:0] RES_10 = 2'h2;
   localparam logic [1:0] RES_16 = 2'h3;

   // Input clock sources
   localparam logic [1:0] CLK_BUS = 2'h0;
   localparam logic [1:0] CLK_BUS_HALF = 2'h1;
   localparam logic [1:0] CLK_ALT = 2'h2;
   localparam logic [1:0] CLK_ASYNC = 2'h3;

   // Reference pairs; the fourth code is not a pair
   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [1:0] REF_ALTERNATE = 2'h1;
   localparam logic [1:0] REF_BANDGAP = 2'h2;

   // Sample window in conversion clock ticks
   localparam logic [4:0] SHORT_SAMPLE_TICKS = 5'h04;
   localparam logic [4:0] LONG_SAMPLE_TICKS = 5'h18;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_DONE} st_t;
endpackage

// [hw/adc_config_control.sv]
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adc_config_control (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic [adc_ctrl_pkg::ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [adc_ctrl_pkg::ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic ALT_CLK_TICK,
   input wire logic ASYNC_CLK_TICK,
   input wire logic HW_TRIGGER,
   input wire logic COMP_HIGH,
   output logic SAMPLE_ENABLE,
   output logic [15:0] DAC_CODE,
   output logic [4:0] CHANNEL_SELECT,
   output logic DIFF_SELECT,
   output logic [1:0] REF_PAIR_SELECT,
   output logic LOW_POWER,
   output logic [15:0] PIN_DIGITAL_DISABLE,
   output logic CONV_IRQ
);
   import adc_ctrl_pkg::*;

   cfg_t cfg_q;
   sc2_t sc2_q;
   sc1_t sc1_q;
   avg_t avg_q;
   logic coco_q;
   logic [15:0] cv_q;
   logic [7:0] pc1_q;
   logic [7:0] pc2_q;
   logic [15:0] result_q;
   logic lock_q;
   st_t st_q;
   logic [15:0] sar_q;
   logic [4:0] bit_q;
   logic [4:0] samp_q;
   logic [2:0] div_q;
   logic half_q;
   logic [20:0] acc_q;
   logic [5:0] avg_cnt_q;
   logic aw_held_q;
   logic w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   logic wr_go;
   logic rd_go;
   logic sw_start;
   logic start;
   logic src_tick;
   logic tick;
   logic [4:0] nbits;
   logic [15:0] full_code;
   logic [5:0] avg_total;
   logic [15:0] final_code;
   logic cmp_ok;
   logic [31:0] rd_word;

   // Bus handshakes; one write and one read outstanding at most
   assign AWREADY = !aw_held_q && !BVALID;
   assign WREADY = !w_held_q && !BVALID;
   assign ARREADY = !RVALID;
   assign wr_go = (aw_held_q || AWVALID) && (w_held_q || WVALID) && !BVALID;
   assign rd_go = ARVALID && !RVALID;

   // Address and data captured in either order
   always_ff @(posedge MCLK) begin
      if (RST) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         if (AWVALID && AWREADY) begin
            awaddr_q <= AWADDR;
         end
         if (WVALID && WREADY) begin
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
         end
         aw_held_q <= (aw_held_q || (AWVALID && AWREADY)) && !wr_go;
         w_held_q <= (w_held_q || (WVALID && WREADY)) && !wr_go;
      end
   end

   logic [ADDR_W-1:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   assign wa = aw_held_q ? awaddr_q : AWADDR;
   assign wd = w_held_q ? wdata_q : WDATA;
   assign ws = w_held_q ? wstrb_q : WSTRB;

   // Write response; unmapped offsets answer with an error
   always_ff @(posedge MCLK) begin
      if (RST) begin
         BVALID <= 1'b0;
         BRESP <= RESP_OKAY;
      end else if (wr_go) begin
         BVALID <= 1'b1;
         BRESP <= (wa > PC2_OFS || wa[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // Software registers; only byte lane 0 matters except reference pair and differential select
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cfg_q <= CFG_RST;
         sc2_q <= SC2_RST;
         sc1_q <= SC1_RST;
         avg_q <= AVG_RST;
         cv_q <= '0;
         pc1_q <= '0;
         pc2_q <= '0;
      end else if (wr_go && ws[0]) begin
         unique case (wa)
            CFG_OFS: cfg_q <= cfg_t'(wd[7:0]);
            SC2_OFS: begin
               // Bits 3:0 are not stored; software writes them zero
               sc2_q.trigger_select <= wd[6];
               sc2_q.compare_function_enable <= wd[5];
               sc2_q.compare_greater_select <= wd[4];
               if (ws[1] && wd[9:8] != 2'h3) begin
                  sc2_q.reference_pair_select <= wd[9:8];
               end
            end
            AVG_OFS: avg_q <= avg_t'(wd[2:0]);
            SC1_OFS: begin
               sc1_q.complete_interrupt_enable <= wd[6];
               sc1_q.continuous_select <= wd[5];
               sc1_q.input_channel_select <= wd[4:0];
               if (ws[1]) begin
                  sc1_q.differential_select <= wd[8];
               end
            end
            CVH_OFS: cv_q[15:8] <= wd[7:0];
            CVL_OFS: cv_q[7:0] <= wd[7:0];
            PC1_OFS: pc1_q <= wd[7:0];
            PC2_OFS: pc2_q <= wd[7:0];
            default: ;
         endcase
      end
   end

   // Read mux; reserved bits and unmapped words read zero
   always_comb begin
      rd_word = '0;
      unique case (ARADDR)
         CFG_OFS: rd_word[7:0] = cfg_q;
         SC2_OFS: begin
            rd_word[7] = (st_q != ST_IDLE);
            rd_word[6:4] = {sc2_q.trigger_select,
                            sc2_q.compare_function_enable,
                            sc2_q.compare_greater_select};
            rd_word[3:0] = 4'h0;
            rd_word[9:8] = sc2_q.reference_pair_select;
         end
         AVG_OFS: rd_word[2:0] = avg_q;
         SC1_OFS: begin
            rd_word[7] = coco_q;
            rd_word[6:0] = {sc1_q.complete_interrupt_enable,
                            sc1_q.continuous_select,
                            sc1_q.input_channel_select};
            rd_word[8] = sc1_q.differential_select;
         end
         RH_OFS: rd_word[7:0] = result_q[15:8];
         RL_OFS: rd_word[7:0] = result_q[7:0];
         CVH_OFS: rd_word[7:0] = cv_q[15:8];
         CVL_OFS: rd_word[7:0] = cv_q[7:0];
         PC1_OFS: rd_word[7:0] = pc1_q;
         PC2_OFS: rd_word[7:0] = pc2_q;
         default: rd_word = '0;
      endcase
   end

   // Read channel, answered one cycle after acceptance
   always_ff @(posedge MCLK) begin
      if (RST) begin
         RVALID <= 1'b0;
         RDATA <= '0;
         RRESP <= RESP_OKAY;
      end else if (rd_go) begin
         RVALID <= 1'b1;
         RDATA <= rd_word;
         RRESP <= (ARADDR > PC2_OFS || ARADDR[1:0] != 2'h0) ?
                  RESP_SLVERR : RESP_OKAY;
      end else if (RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // Input clock source, then divide by 1, 2, 4 or 8
   always_comb begin
      unique case (cfg_q.input_clock_select)
         CLK_BUS: src_tick = 1'b1;
         CLK_BUS_HALF: src_tick = half_q;
         CLK_ALT: src_tick = ALT_CLK_TICK;
         CLK_ASYNC: src_tick = ASYNC_CLK_TICK;
      endcase
   end
   assign tick = src_tick &&
      ((div_q & ((3'h1 << cfg_q.clock_divide_select) - 3'h1)) == 3'h0);

   // Divider counter advances on each source tick
   always_ff @(posedge MCLK) begin
      if (RST) begin
         half_q <= 1'b0;
         div_q <= '0;
      end else begin
         half_q <= !half_q;
         if (src_tick) begin
            div_q <= div_q + 3'h1;
         end
      end
   end

   // Result width from resolution and input mode
   always_comb begin
      unique case (cfg_q.resolution_select)
         RES_8: nbits = sc1_q.differential_select ? 5'd9 : 5'd8;
         RES_12: nbits = sc1_q.differential_select ? 5'd13 : 5'd12;
         RES_10: nbits = sc1_q.differential_select ? 5'd11 : 5'd10;
         RES_16: nbits = 5'd16;
      endcase
      full_code = 16'((17'h1 << nbits) - 17'h1);
   end

   // Averaging count of 4, 8, 16 or 32 samples
   assign avg_total = avg_q.averaging_enable ?
      6'(6'h4 << avg_q.average_count_select) : 6'h1;
   // Last sample is not yet in acc_q at DONE, so it is added here
   assign final_code = avg_q.averaging_enable ?
      16'((acc_q + 21'(sar_q)) >> (5'd2 + 5'(avg_q.average_count_select)))
      : sar_q;
   // Compare gate on the very code that would be stored
   assign cmp_ok = !sc2_q.compare_function_enable ||
      (sc2_q.compare_greater_select ? (final_code >= cv_q)
                                    : (final_code < cv_q));

   // A channel register write restarts a software conversion
   assign sw_start = wr_go && ws[0] && wa == SC1_OFS;
   assign start = sc2_q.trigger_select ? HW_TRIGGER : sw_start;

   // Conversion sequencer: sample window, then one bit per tick
   always_ff @(posedge MCLK) begin
      if (RST) begin
         st_q <= ST_IDLE;
         sar_q <= '0;
         bit_q <= '0;
         samp_q <= '0;
         acc_q <= '0;
         avg_cnt_q <= '0;
      end else if (sw_start) begin
         // Software write aborts whatever was running
         st_q <= sc2_q.trigger_select ? ST_IDLE : ST_SAMPLE;
         samp_q <= '0;
         acc_q <= '0;
         avg_cnt_q <= '0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (start) begin
                  st_q <= ST_SAMPLE;
                  samp_q <= '0;
                  acc_q <= '0;
                  avg_cnt_q <= '0;
               end
            end
            ST_SAMPLE: begin
               if (tick) begin
                  samp_q <= samp_q + 5'h1;
                  if (samp_q + 5'h1 >= (cfg_q.long_sample_select ?
                        LONG_SAMPLE_TICKS : SHORT_SAMPLE_TICKS)) begin
                     st_q <= ST_CONVERT;
                     sar_q <= '0;
                     bit_q <= nbits - 5'h1;
                  end
               end
            end
            ST_CONVERT: begin
               if (tick) begin
                  // Comparator high keeps the trial bit; an input at
                  // or over the top keeps all, at the floor keeps none
                  if (COMP_HIGH) begin
                     sar_q[bit_q[3:0]] <= 1'b1;
                  end
                  if (bit_q == 5'h0) begin
                     st_q <= ST_DONE;
                  end else begin
                     bit_q <= bit_q - 5'h1;
                  end
               end
            end
            ST_DONE: begin
               acc_q <= acc_q + 21'(sar_q);
               avg_cnt_q <= avg_cnt_q + 6'h1;
               samp_q <= '0;
               if (avg_cnt_q + 6'h1 < avg_total) begin
                  st_q <= ST_SAMPLE;
               end else if (sc1_q.continuous_select) begin
                  st_q <= ST_SAMPLE;
                  acc_q <= '0;
                  avg_cnt_q <= '0;
               end else begin
                  st_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   logic finish;
   logic [15:0] store_code;
   assign finish = (st_q == ST_DONE) && (avg_cnt_q + 6'h1 >= avg_total);
   // Stored code is the compared code, so the two cannot disagree
   assign store_code = final_code;

   // Result transfer, lock and complete flag; set beats clear
   always_ff @(posedge MCLK) begin
      if (RST) begin
         result_q <= '0;
         lock_q <= 1'b0;
         coco_q <= 1'b0;
      end else begin
         if (rd_go && ARADDR == RH_OFS) begin
            lock_q <= 1'b1;
         end else if (rd_go && ARADDR == RL_OFS) begin
            lock_q <= 1'b0;
         end
         if (finish && !lock_q && cmp_ok) begin
            // Locked results are kept; the new one is dropped
            result_q <= (store_code > full_code) ? full_code : store_code;
            coco_q <= 1'b1;
         end else if (sw_start || (rd_go && ARADDR == RL_OFS)) begin
            coco_q <= 1'b0;
         end
      end
   end

   // Analog side controls
   assign SAMPLE_ENABLE = (st_q == ST_SAMPLE);
   assign DAC_CODE = sar_q | ((st_q == ST_CONVERT) ?
      16'(17'h1 << bit_q) : 16'h0);
   assign CHANNEL_SELECT = sc1_q.input_channel_select;
   assign DIFF_SELECT = sc1_q.differential_select;
   assign REF_PAIR_SELECT = sc2_q.reference_pair_select;
   assign LOW_POWER = cfg_q.low_power_config;
   // Bit n of the pair drives pin of channel n
   assign PIN_DIGITAL_DISABLE = {pc2_q, pc1_q};
   assign CONV_IRQ = coco_q && sc1_q.complete_interrupt_enable;
endmodule
`default_nettype wire

// [verif/adc_cfg_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module adc_cfg_sva (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [adc_ctrl_pkg::ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic SAMPLE_ENABLE,
   input wire logic [4:0] CHANNEL_SELECT,
   input wire logic DIFF_SELECT,
   input wire logic [1:0] REF_PAIR_SELECT,
   input wire logic LOW_POWER,
   input wire logic [15:0] PIN_DIGITAL_DISABLE,
   input wire logic CONV_IRQ
);
   import adc_ctrl_pkg::*;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);

   // Bus hand-offs; the wires feed $past, the sequences antecedents
   wire logic wr_go = (AWVALID && AWREADY) || (WVALID && WREADY);
   wire logic rd_go = ARVALID && ARREADY;
   sequence rd_take;
      ARVALID && ARREADY;
   endsequence
   sequence wr_take;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence

   a_rd_answer: assert property (rd_take |=> RVALID)
      else $error("read not answered one cycle after address");
   a_wr_answer: assert property (wr_take |=> BVALID)
      else $error("write not answered one cycle after transfer");
   a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped before taken");
   a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped before taken");
   a_ar_block: assert property (ARREADY == !RVALID)
      else $error("read address ready wrong");
   a_rd_unmapped: assert property (rd_take ##0 (ARADDR > 8'h24)
      |=> RRESP == RESP_SLVERR && RDATA == 32'h0)
      else $error("unmapped read not refused");
   // Register-driven outputs move only after a write or a reset
   a_cfg_by_write: assert property ($changed({LOW_POWER, REF_PAIR_SELECT,
      CHANNEL_SELECT, DIFF_SELECT, PIN_DIGITAL_DISABLE})
      |-> $past(RST) || $past(wr_go))
      else $error("control output changed without a write");
   a_irq_clear: assert property ($fell(CONV_IRQ) |-> $past(RST) ||
      $past(wr_go) || $past(rd_go) || $past(rd_go, 2))
      else $error("complete flag cleared with no access");
   a_sample_min: assert property ($rose(SAMPLE_ENABLE)
      |-> SAMPLE_ENABLE[*4])
      else $error("sample window shorter than four ticks");
endmodule

bind adc_config_control adc_cfg_sva chk (.MCLK(MCLK), .RST(RST),
   .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
   .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
   .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
   .RVALID(RVALID), .RREADY(RREADY), .SAMPLE_ENABLE(SAMPLE_ENABLE),
   .CHANNEL_SELECT(CHANNEL_SELECT), .DIFF_SELECT(DIFF_SELECT),
   .REF_PAIR_SELECT(REF_PAIR_SELECT), .LOW_POWER(LOW_POWER),
   .PIN_DIGITAL_DISABLE(PIN_DIGITAL_DISABLE), .CONV_IRQ(CONV_IRQ));
`default_nettype wire

// [verif/adc_config_control_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module adc_config_control_tb_top;
   import adc_ctrl_pkg::*;
   logic MCLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
   logic ARVALID = 0, RREADY = 0, HW_TRIGGER = 0, COMP_HIGH = 0;
   logic ALT_CLK_TICK = 0, ASYNC_CLK_TICK = 0;
   addr_t AWADDR = 0, ARADDR = 0;
   logic [31:0] WDATA = 0, RDATA, rd;
   logic [3:0] WSTRB = 4'hF, stb = 4'hF;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic SAMPLE_ENABLE, DIFF_SELECT, LOW_POWER, CONV_IRQ;
   logic [1:0] BRESP, RRESP, REF_PAIR_SELECT, rsp;
   logic [15:0] DAC_CODE, PIN_DIGITAL_DISABLE;
   logic [4:0] CHANNEL_SELECT;
   int error_cnt = 0, compares = 0;

   adc_config_control uut (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .ALT_CLK_TICK(ALT_CLK_TICK),
      .ASYNC_CLK_TICK(ASYNC_CLK_TICK), .HW_TRIGGER(HW_TRIGGER),
      .COMP_HIGH(COMP_HIGH), .SAMPLE_ENABLE(SAMPLE_ENABLE),
      .DAC_CODE(DAC_CODE), .CHANNEL_SELECT(CHANNEL_SELECT),
      .DIFF_SELECT(DIFF_SELECT), .REF_PAIR_SELECT(REF_PAIR_SELECT),
      .LOW_POWER(LOW_POWER), .PIN_DIGITAL_DISABLE(PIN_DIGITAL_DISABLE),
      .CONV_IRQ(CONV_IRQ));

   // 100 MHz clock
   always #5 MCLK = ~MCLK;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("mismatches %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Bounded waits; a hang counts as a mismatch
   task automatic guard(inout int n);
      n++;
      if (n > 400) begin
         error_cnt++;
         stop_test();
      end
   endtask

   // Ready sampled at the falling edge, so the rising edge sees the same
   task automatic bus_wr(input addr_t a, input logic [31:0] d);
      int n;
      logic pa, pw, got;
      n = 0;
      pa = 1'b1;
      pw = 1'b1;
      got = 1'b0;
      @(posedge MCLK);
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= stb;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!got) begin
         @(negedge MCLK);
         got = !pa && !pw && BVALID;
         rsp = BRESP;
         pa = pa && !AWREADY;
         pw = pw && !WREADY;
         @(posedge MCLK);
         AWVALID <= pa;
         WVALID <= pw;
         BREADY <= !got;
         guard(n);
      end
      @(negedge MCLK);
   endtask

   task automatic bus_rd(input addr_t a);
      int n;
      logic pa, got;
      n = 0;
      pa = 1'b1;
      got = 1'b0;
      @(posedge MCLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      while (!got) begin
         @(negedge MCLK);
         got = !pa && RVALID;
         rd = RDATA;
         rsp = RRESP;
         pa = pa && !ARREADY;
         @(posedge MCLK);
         ARVALID <= pa;
         RREADY <= !got;
         guard(n);
      end
      @(negedge MCLK);
   endtask

   task automatic rd_chk(input addr_t a, input logic [31:0] e);
      bus_rd(a);
      check(rd, e);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      do begin
         @(negedge MCLK);
         guard(n);
      end while (CONV_IRQ !== 1'b1);
   endtask

   task automatic t_reset();
      rd_chk(CFG_OFS, 32'h0);
      rd_chk(SC2_OFS, 32'h0);
      rd_chk(SC1_OFS, 32'h1F);
      rd_chk(AVG_OFS, 32'h0);
      check(32'(CHANNEL_SELECT), 32'h1F);
      check(32'(PIN_DIGITAL_DISABLE), 32'h0);
   endtask

   // Unmapped and misaligned places are refused
   task automatic t_unmapped();
      bus_wr(8'h28, 32'hFF);
      check(32'(rsp), 32'(RESP_SLVERR));
      rd_chk(8'h28, 32'h0);
      check(32'(rsp), 32'(RESP_SLVERR));
      bus_rd(8'h02);
      check(32'(rsp), 32'(RESP_SLVERR));
   endtask

   task automatic t_config();
      logic [31:0] e;
      bus_wr(CFG_OFS, 32'h98);
      rd_chk(CFG_OFS, 32'h98);
      check(32'(LOW_POWER), 32'h1);
      // Bits 3:0 read zero; code 3 is no pair and leaves code 2
      for (int r = 0; r < 4; r++) begin
         bus_wr(SC2_OFS, 32'(r * 256 + 'hFC));
         if (r < 3) e = 32'(r * 256 + 'h70);
         rd_chk(SC2_OFS, e);
         check(32'(REF_PAIR_SELECT), 32'(e[9:8]));
      end
      bus_wr(SC2_OFS, 32'h0);
      bus_wr(AVG_OFS, 32'h7);
      rd_chk(AVG_OFS, 32'h7);
      bus_wr(AVG_OFS, 32'h0);
      bus_wr(CVH_OFS, 32'h02);
      bus_wr(CVL_OFS, 32'h00);
      rd_chk(CVH_OFS, 32'h02);
      bus_wr(PC1_OFS, 32'h02);
      bus_wr(PC2_OFS, 32'h80);
      check(32'(PIN_DIGITAL_DISABLE), 32'h8002);
      stb = 4'hE;
      bus_wr(PC1_OFS, 32'hFF);
      stb = 4'hF;
      check(32'(PIN_DIGITAL_DISABLE), 32'h8002);
   endtask

   // Rows: config, compare control, comparator level, expected result
   task automatic t_convert();
      logic [7:0] cf [5] = '{8'h98, 8'h98, 8'h80, 8'h84, 8'h98};
      logic [7:0] s2 [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h30};
      logic cm [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      logic [15:0] res [5] = '{16'h3FF, 16'h0, 16'hFF, 16'hFFF, 16'h3FF};
      for (int i = 0; i < 5; i++) begin
         bus_wr(CFG_OFS, 32'(cf[i]));
         bus_wr(SC2_OFS, 32'(s2[i]));
         @(posedge MCLK);
         COMP_HIGH <= cm[i];
         bus_wr(SC1_OFS, 32'h41);
         bus_rd(SC2_OFS);
         check(32'(rd[7]), 32'h1);
         wait_irq();
         check(32'(DAC_CODE), 32'(res[i]));
         rd_chk(SC1_OFS, 32'hC1);
         check(32'(CHANNEL_SELECT), 32'h1);
         rd_chk(RH_OFS, 32'(res[i][15:8]));
         rd_chk(RL_OFS, 32'(res[i][7:0]));
         check(32'(CONV_IRQ), 32'h0);
      end
   endtask

   // A conversion landing between high and low reads is dropped
   task automatic t_lock();
      int n;
      n = 0;
      bus_wr(SC2_OFS, 32'h0);
      bus_wr(SC1_OFS, 32'h41);
      wait_irq();
      rd_chk(RH_OFS, 32'h03);
      @(posedge MCLK);
      COMP_HIGH <= 1'b0;
      bus_wr(SC1_OFS, 32'h41);
      do begin
         bus_rd(SC2_OFS);
         guard(n);
      end while (rd[7] !== 1'b0);
      rd_chk(RL_OFS, 32'hFF);
      rd_chk(RH_OFS, 32'h03);
      // Low read unlocks again, else later results would be dropped
      rd_chk(RL_OFS, 32'hFF);
   endtask

   task automatic t_hwtrig();
      bus_wr(SC2_OFS, 32'h40);
      bus_wr(SC1_OFS, 32'h41);
      rd_chk(SC2_OFS, 32'h40);
      @(posedge MCLK);
      HW_TRIGGER <= 1'b1;
      COMP_HIGH <= 1'b1;
      @(posedge MCLK);
      HW_TRIGGER <= 1'b0;
      wait_irq();
      rd_chk(RH_OFS, 32'h03);
      rd_chk(RL_OFS, 32'hFF);
      bus_wr(SC2_OFS, 32'h0);
   endtask

   // Halved bus clock, divide by two, differential, four-sample average
   task automatic t_modes();
      bus_wr(CFG_OFS, 32'h29);
      bus_wr(SC2_OFS, 32'h0);
      bus_wr(AVG_OFS, 32'h4);
      COMP_HIGH <= 1'b1;
      bus_wr(SC1_OFS, 32'h141);
      rd_chk(CFG_OFS, 32'h29);
      check(32'(DIFF_SELECT), 32'h1);
      wait_irq();
      rd_chk(SC1_OFS, 32'h1C1);
      rd_chk(RH_OFS, 32'h07);
      rd_chk(RL_OFS, 32'hFF);
      bus_wr(AVG_OFS, 32'h0);
      bus_wr(CFG_OFS, 32'h98);
   endtask

   // Second completion needs no new start in continuous mode
   task automatic t_cont();
      bus_wr(SC1_OFS, 32'h61);
      wait_irq();
      rd_chk(RH_OFS, 32'h03);
      rd_chk(RL_OFS, 32'hFF);
      wait_irq();
      rd_chk(SC1_OFS, 32'hE1);
      bus_wr(SC1_OFS, 32'h101);
      check(32'(DIFF_SELECT), 32'h1);
   endtask

   // Reset, then the scenarios in turn
   initial begin
      repeat (16) @(posedge MCLK);
      RST <= 1'b0;
      t_reset();
      t_unmapped();
      t_config();
      t_convert();
      t_lock();
      t_hwtrig();
      t_modes();
      t_cont();
      stop_test();
   end
endmodule
`default_nettype wire
